// ---- design/opd_top.sv ----
`timescale 1ns/10ps
module opd_top import opd_pkg::*; #(
    parameter int STEP_CYCLES = OPD_STEP_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] negSeqMag,
    input wire logic [15:0] posSeqMag,
    input wire logic breakerClosed,
    input wire logic [OPD_NOC-1:0] ocPickup,
    output logic pickup,
    output logic trip,
    output logic irq
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic ctrlEn;
        logic [5:0] pickSet;
        logic [15:0] waitSet;
        logic [15:0] minLoad;
        logic [OPD_NEV-1:0] status;
        logic [OPD_NEV-1:0] mask;
        opd_state_t fsm;
        logic [31:0] presc;
        logic [15:0] ticks;
        logic pickupQ;
        logic tripQ;
        logic irqQ;
        logic readyQ;
        logic [31:0] rdata;
        logic wrPend;
        logic [OPD_ADDR_W-1:0] wrAddr;
    } opd_regs_t;

    opd_regs_t st_q;
    opd_regs_t st_d;
    logic active;
    logic blocked;
    logic ratioAbove;
    logic ratioBelow;
    logic busSel;
    logic [31:0] lhs;
    logic [31:0] rhsBase;
    logic [OPD_NEV-1:0] events;

    assign hrdata = st_q.rdata;
    assign hreadyout = st_q.readyQ;
    // Zero wait states, so the response never leaves OKAY
    assign hresp = 1'b0;
    assign pickup = st_q.pickupQ;
    assign trip = st_q.tripQ;
    assign irq = st_q.irqQ;

    // ****************************************
    // Measurement
    // ****************************************
    // Ratio compared by cross multiplication; no divider in the loop
    // Products fit 32 bits for 16-bit magnitudes and a 6-bit setting
    assign lhs = 32'(negSeqMag) * OPD_SET_SCALE * OPD_PCT_SCALE;
    assign rhsBase = 32'(st_q.pickSet) * 32'(posSeqMag);
    assign ratioAbove = lhs > rhsBase * OPD_PU_PCT;
    assign ratioBelow = lhs <= rhsBase * OPD_DO_PCT;
    assign blocked = |ocPickup;
    assign active = st_q.ctrlEn && breakerClosed && (posSeqMag >= st_q.minLoad)
        && !blocked;
    assign busSel = hsel && htrans[1] && hready;

    function automatic logic [31:0] opd_read(input opd_regs_t s, input logic [4:0] a);
        case (a)
            OPD_ADDR_CTRL: opd_read = 32'(s.ctrlEn);
            OPD_ADDR_PICKUP: opd_read = 32'(s.pickSet);
            OPD_ADDR_WAIT: opd_read = 32'(s.waitSet);
            OPD_ADDR_MINLOAD: opd_read = 32'(s.minLoad);
            OPD_ADDR_STATE: opd_read = {28'h0000000, !active, s.ctrlEn, s.tripQ, s.pickupQ};
            OPD_ADDR_STATUS: opd_read = 32'(s.status);
            OPD_ADDR_MASK: opd_read = 32'(s.mask);
            default: opd_read = 32'h0000_0000;
        endcase
    endfunction : opd_read

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_d = st_q;
        st_d.readyQ = 1'b1;
        // Element sequencing
        case (st_q.fsm)
            OPD_OFF: begin
                if (active) begin
                    st_d.fsm = OPD_ARMED;
                end
            end
            OPD_ARMED: begin
                if (!active) begin
                    st_d.fsm = OPD_OFF;
                end else if (ratioAbove) begin
                    st_d.fsm = OPD_PICKED;
                end
            end
            OPD_PICKED: begin
                if (!active) begin
                    st_d.fsm = OPD_OFF;
                end else if (ratioBelow) begin
                    st_d.fsm = OPD_ARMED;
                end else if (st_q.ticks >= st_q.waitSet) begin
                    st_d.fsm = OPD_TRIPPED;
                end
            end
            OPD_TRIPPED: begin
                if (!active) begin
                    st_d.fsm = OPD_OFF;
                end else if (ratioBelow) begin
                    st_d.fsm = OPD_ARMED;
                end
            end
            default: st_d.fsm = OPD_OFF;
        endcase
        // Wait timer runs only while picked; any drop restarts it from zero
        if (st_d.fsm == OPD_PICKED && st_q.fsm == OPD_PICKED) begin
            if (st_q.presc >= 32'(STEP_CYCLES - 1)) begin
                st_d.presc = 32'h0000_0000;
                st_d.ticks = st_q.ticks + 16'h0001;
            end else begin
                st_d.presc = st_q.presc + 32'h0000_0001;
            end
        end else begin
            st_d.presc = 32'h0000_0000;
            st_d.ticks = 16'h0000;
        end
        st_d.pickupQ = (st_d.fsm == OPD_PICKED) || (st_d.fsm == OPD_TRIPPED);
        st_d.tripQ = (st_d.fsm == OPD_TRIPPED);
        // Bus: read data registered at address phase, write applied in data phase
        st_d.wrPend = busSel && hwrite;
        if (busSel) begin
            st_d.wrAddr = haddr[OPD_ADDR_W-1:0];
        end
        if (busSel && !hwrite) begin
            st_d.rdata = opd_read(st_q, haddr[OPD_ADDR_W-1:0]);
        end
        if (st_q.wrPend) begin
            case (st_q.wrAddr)
                OPD_ADDR_CTRL: st_d.ctrlEn = hwdata[0];
                OPD_ADDR_PICKUP: st_d.pickSet = hwdata[5:0];
                OPD_ADDR_WAIT: st_d.waitSet = hwdata[15:0];
                OPD_ADDR_MINLOAD: st_d.minLoad = hwdata[15:0];
                OPD_ADDR_STATUS: st_d.status = st_q.status & ~hwdata[OPD_NEV-1:0];
                OPD_ADDR_MASK: st_d.mask = hwdata[OPD_NEV-1:0];
                default: st_d.ctrlEn = st_q.ctrlEn;
            endcase
        end
        // New events set after the clear so a coincident event is kept
        events[OPD_EV_PICK] = st_d.pickupQ && !st_q.pickupQ;
        events[OPD_EV_TRIP] = st_d.tripQ && !st_q.tripQ;
        st_d.status = st_d.status | events;
        st_d.irqQ = |(st_d.status & st_d.mask);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
            st_q.pickSet <= OPD_RST_PICKUP;
            st_q.waitSet <= OPD_RST_WAIT;
            st_q.minLoad <= OPD_RST_MINLOAD;
            st_q.fsm <= OPD_OFF;
            st_q.readyQ <= 1'b1;
        end else if (clkEn) begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst || !clkEn);

    a_trip_has_pickup: assert property (trip |-> pickup)
        else $error("trip without pickup");
    a_trip_after_wait: assert property ($rose(trip) |-> $past(st_q.ticks) >= st_q.waitSet)
        else $error("trip before wait time");
    a_enable_off: assert property (!st_q.ctrlEn && clkEn |=> !pickup && !trip)
        else $error("outputs set while disabled");
    a_breaker_open: assert property (!breakerClosed && clkEn |=> !pickup)
        else $error("pickup with breaker open");
    a_low_load: assert property (posSeqMag < st_q.minLoad && clkEn |=> !pickup)
        else $error("pickup below minimum load");
    a_oc_block: assert property (|ocPickup && clkEn |=> !pickup && !trip)
        else $error("pickup during overcurrent pickup");
    a_pick_rise: assert property (st_q.fsm == OPD_ARMED && active && ratioAbove
        |=> pickup)
        else $error("ratio above pickup but no pickup");
    a_drop_low: assert property (pickup && ratioBelow |=> !pickup)
        else $error("pickup held below dropout level");
    a_trip_needs_wait: assert property (pickup && !trip && st_q.ticks < st_q.waitSet
        |=> !trip)
        else $error("trip before timer reached wait");
    a_inactive_clear: assert property (!active |=> !pickup && !trip)
        else $error("outputs set while element inhibited");
    a_hyst_hold: assert property (pickup && active && !ratioBelow && clkEn |=> pickup)
        else $error("pickup dropped inside hysteresis band");
    a_timer_reset: assert property (!pickup |-> st_q.ticks == 16'h0000)
        else $error("timer not restarted");

    c_pickup: cover property ($rose(pickup));
    c_trip: cover property ($rose(trip));
    c_drop_before_trip: cover property (pickup && !trip ##1 !pickup);
    c_irq: cover property ($rose(irq));
endmodule : opd_top

// ---- design/opd_pkg.sv ----
// Contract
// - Monitor negative to positive sequence current ratio
// - Pick up when ratio exceeds setting
// - Pick up above 1.02x, drop at 0.97x
// - Trip after continuous pickup for wait time
// - Disabled while breaker open or load low
// - Blocked by any overcurrent element pickup
package opd_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] OPD_ADDR_CTRL = 5'h00;
    localparam logic [4:0] OPD_ADDR_PICKUP = 5'h04;
    localparam logic [4:0] OPD_ADDR_WAIT = 5'h08;
    localparam logic [4:0] OPD_ADDR_MINLOAD = 5'h0c;
    localparam logic [4:0] OPD_ADDR_STATE = 5'h10;
    localparam logic [4:0] OPD_ADDR_STATUS = 5'h14;
    localparam logic [4:0] OPD_ADDR_MASK = 5'h18;
    localparam int OPD_ADDR_W = 5;
    // Pickup setting in hundredths of I2/I1, wait in 10 ms steps, load in current lsbs
    localparam logic [5:0] OPD_RST_PICKUP = 6'h05;
    localparam logic [15:0] OPD_RST_WAIT = 16'h000a; // 100 ms
    localparam logic [15:0] OPD_RST_MINLOAD = 16'h0032;
    localparam int OPD_EV_PICK = 0;
    localparam int OPD_EV_TRIP = 1;
    localparam int OPD_NEV = 2;
    localparam int OPD_NOC = 4;
    // ****************************************
    // Hysteresis and timing
    // ****************************************
    localparam logic [31:0] OPD_SET_SCALE = 32'h0000_0064;
    localparam logic [31:0] OPD_PCT_SCALE = 32'h0000_0064;
    localparam logic [31:0] OPD_PU_PCT = 32'h0000_0066;
    localparam logic [31:0] OPD_DO_PCT = 32'h0000_0061;
    localparam int OPD_CLK_MHZ = 250;
    localparam int OPD_STEP_MS = 10;
    localparam int OPD_STEP_CYC = OPD_STEP_MS * 1000 * OPD_CLK_MHZ;
    typedef enum logic [3:0] {
        OPD_OFF = 4'b0001,
        OPD_ARMED = 4'b0010,
        OPD_PICKED = 4'b0100,
        OPD_TRIPPED = 4'b1000
    } opd_state_t;
endpackage : opd_pkg

// ---- dv/open_phase_unbalance_detector_tb.sv ----
`timescale 1ns/10ps
module open_phase_unbalance_detector_tb import opd_pkg::*;;
    logic clock = 0, nrst = 0, hsel = 0, hwrite = 0, breakerClosed = 0, clkEn = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [15:0] negSeqMag = 0, posSeqMag = 0;
    logic [3:0] ocPickup = 0;
    logic hreadyout, hresp, pickup, trip, irq;
    int errors = 0, n_compared = 0;
    always #2 clock = ~clock;
    // Short prescaler keeps the wait time to a few dozen cycles
    opd_top #(.STEP_CYCLES(4)) DUT (.clock(clock), .nrst(nrst), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .negSeqMag(negSeqMag), .posSeqMag(posSeqMag), .breakerClosed(breakerClosed),
        .ocPickup(ocPickup), .pickup(pickup), .trip(trip), .irq(irq));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1; haddr <= {27'h0, a}; htrans <= 2'h2; hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic drive(input logic [15:0] n, input logic [15:0] p, input logic b,
                         input logic [3:0] o);
        @(posedge clock);
        negSeqMag <= n; posSeqMag <= p; breakerClosed <= b; ocPickup <= o;
        tick(3);
    endtask : drive
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] exp [8] = '{32'h0, 32'h5, 32'ha, 32'h32, 32'h8, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 8; i++) begin
            ahb(5'(i * 4), 1'b0, 32'h0);
            chk(rd, exp[i]);
        end
        chk({pickup, trip, irq, hresp, hreadyout}, 5'h01);
    endtask : t_reset
    task automatic t_hyst();
        // Ratio setting 0.20 on 1000 counts: on above 204, off at 194 and below
        ahb(OPD_ADDR_PICKUP, 1'b1, 32'd20);
        ahb(OPD_ADDR_WAIT, 1'b1, 32'd10);
        ahb(OPD_ADDR_MASK, 1'b1, 32'h1);
        ahb(OPD_ADDR_CTRL, 1'b1, 32'h1);
        drive(16'd204, 16'd1000, 1'b1, 4'h0);
        chk(pickup, 1'b0);
        drive(16'd205, 16'd1000, 1'b1, 4'h0);
        chk({pickup, irq}, 2'b11);
        drive(16'd195, 16'd1000, 1'b1, 4'h0);
        chk(pickup, 1'b1);
        drive(16'd194, 16'd1000, 1'b1, 4'h0);
        chk({pickup, trip}, 2'b00);
    endtask : t_hyst
    task automatic t_trip();
        ahb(OPD_ADDR_STATUS, 1'b1, 32'h3);
        drive(16'd400, 16'd1000, 1'b1, 4'h0);
        tick(19);
        drive(16'd100, 16'd1000, 1'b1, 4'h0);
        drive(16'd400, 16'd1000, 1'b1, 4'h0);
        // A timer that missed the drop would have tripped by now
        tick(13);
        chk({pickup, trip}, 2'b10);
        // Wait of 10 steps of 4 cycles: trip on the 41st edge after pickup
        tick(25);
        chk(trip, 1'b0);
        tick(1);
        chk(trip, 1'b1);
        ahb(OPD_ADDR_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h3);
        ahb(OPD_ADDR_MASK, 1'b1, 32'h0);
        tick(1);
        chk(irq, 1'b0);
        ahb(OPD_ADDR_MASK, 1'b1, 32'h3);
        tick(1);
        chk(irq, 1'b1);
        ahb(OPD_ADDR_STATUS, 1'b1, 32'h3);
        tick(1);
        chk(irq, 1'b0);
    endtask : t_trip
    task automatic t_inhibit();
        logic [36:0] tbl [6] = '{{16'd400, 16'd1000, 1'b0, 4'h0}, {16'd20, 16'd40, 1'b1, 4'h0},
            {16'd400, 16'd1000, 1'b1, 4'h1}, {16'd400, 16'd1000, 1'b1, 4'h2},
            {16'd400, 16'd1000, 1'b1, 4'h4}, {16'd400, 16'd1000, 1'b1, 4'h8}};
        for (int i = 0; i < 6; i++) begin
            drive(tbl[i][36:21], tbl[i][20:5], tbl[i][4], tbl[i][3:0]);
            chk({pickup, trip}, 2'b00);
            drive(16'd400, 16'd1000, 1'b1, 4'h0);
            chk(pickup, 1'b1);
        end
    endtask : t_inhibit
    task automatic t_enable();
        tick(45);
        chk({pickup, trip}, 2'b11);
        ahb(OPD_ADDR_CTRL, 1'b1, 32'h0);
        tick(2);
        chk({pickup, trip}, 2'b00);
        ahb(OPD_ADDR_STATE, 1'b0, 32'h0);
        chk(rd, 32'h8);
        ahb(OPD_ADDR_CTRL, 1'b1, 32'h1);
        tick(8);
        chk({pickup, trip}, 2'b10);
        // Timing restarts from zero: full wait counted again
        tick(34);
        chk(trip, 1'b0);
        tick(1);
        chk(trip, 1'b1);
    endtask : t_enable
    task automatic t_freeze();
        @(posedge clock);
        clkEn <= 1'b0;
        drive(16'd400, 16'd1000, 1'b0, 4'h0);
        chk({pickup, trip}, 2'b11);
        @(posedge clock);
        clkEn <= 1'b1;
        tick(2);
        chk({pickup, trip}, 2'b00);
    endtask : t_freeze
    task automatic summarize();
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    initial begin
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_hyst();
        t_trip();
        t_inhibit();
        t_enable();
        t_freeze();
        summarize();
    end
    initial begin
        #40000;
        errors++;
        summarize();
    end
endmodule : open_phase_unbalance_detector_tb
